// ==== logic/lock_ident_map.svh ====
// Offsets, field positions, reset values and the EEPROM word width for the lock and identification block.
// =====================================================================
`ifndef LOCK_IDENT_MAP_SVH
`define LOCK_IDENT_MAP_SVH
`define OFS_SUBSYS_IDENT 8'h40
`define OFS_SYSTEM_CONTROL 8'h80
`define OFS_MFUNC_ROUTING 8'h8C
`define BIT_IDENT_WRITE_ENABLE 5
`define TERM4_FIELD_LSB 16
`define TERM4_SEL_LOCK 4'h7
`define LOCK_BLOCK_LSB 4
`define SYSCTL_RESET 32'h0000_0000
`define ROUTING_RESET 32'h0000_0000
`define IDENT_RESET 32'h0000_0000
`define EEPROM_WORD_BITS 32
`endif

// ==== logic/lock_ident_pkg.sv ====
// Types shared by the lock and identification block.
`default_nettype none
package lock_ident_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic func;
        logic [7:0] addr;
        logic [31:0] wdata;
    } cfg_req_s;

    typedef struct packed {
        logic valid;
        logic downstream;
        logic write;
        logic locked;
        logic [31:0] addr;
    } xact_s;

    typedef enum logic [1:0] {
        LK_IDLE,
        LK_ACQUIRE,
        LK_HELD
    } lock_state_e;

    typedef enum logic [1:0] {
        EE_IDLE,
        EE_SHIFT,
        EE_DONE
    } ee_state_e;
endpackage
`default_nettype wire

// ==== logic/pci_lock_and_subsystem_id.sv ====
// Lock handling, write-posting control and subsystem identification load for the bridge.
`timescale 1ns/10ps
`include "lock_ident_map.svh"
`default_nettype none
module pci_lock_and_subsystem_id #(
    parameter int EE_BITS = `EEPROM_WORD_BITS
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic global_reset_input,
    input wire logic suspend_in,
    input wire lock_ident_pkg::cfg_req_s cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    input wire logic lock_pin_in,
    input wire logic multipurpose_terminal_four_in,
    input wire lock_ident_pkg::xact_s xact,
    output logic xact_allow,
    output logic posting_enable,
    input wire logic card_side_lock_in,
    output logic card_side_lock_out,
    output logic card_side_lock_oe,
    input wire logic ee_data_in,
    input wire logic ee_bit_valid,
    output logic ee_busy
);
    import lock_ident_pkg::*;

    // =================================================================
    // Reset gating
    // Suspend keeps the bus reset away from every register of the core.
    logic core_rst;
    assign core_rst = sys_rst && !suspend_in;

    // =================================================================
    // Configuration registers
    logic [31:0] sysctl_r, sysctl_nxt;
    logic [31:0] routing_r, routing_nxt;
    logic [31:0] ident_r, ident_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    logic ee_load;
    logic [31:0] ee_word;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    always_comb begin
        sysctl_nxt = sysctl_r;
        routing_nxt = routing_r;
        ident_nxt = ident_r;
        rdata_nxt = rdata_r;
        ack_nxt = cfg_req.valid;
        if (cfg_req.valid && cfg_req.write) begin
            if (hit(cfg_req.addr, `OFS_SYSTEM_CONTROL)) begin
                sysctl_nxt = cfg_req.wdata;
            end
            if (hit(cfg_req.addr, `OFS_MFUNC_ROUTING)) begin
                routing_nxt = cfg_req.wdata;
            end
            // Both functions share one identification word.
            if (hit(cfg_req.addr, `OFS_SUBSYS_IDENT)
                    && sysctl_r[`BIT_IDENT_WRITE_ENABLE]) begin
                ident_nxt = cfg_req.wdata;
            end
        end
        if (ee_load) begin
            ident_nxt = ee_word;
        end
        if (cfg_req.valid && !cfg_req.write) begin
            if (hit(cfg_req.addr, `OFS_SUBSYS_IDENT)) begin
                rdata_nxt = ident_r;
            end else if (hit(cfg_req.addr, `OFS_SYSTEM_CONTROL)) begin
                rdata_nxt = sysctl_r;
            end else if (hit(cfg_req.addr, `OFS_MFUNC_ROUTING)) begin
                rdata_nxt = routing_r;
            end else begin
                rdata_nxt = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (core_rst) begin
            sysctl_r <= `SYSCTL_RESET;
            routing_r <= `ROUTING_RESET;
            ident_r <= `IDENT_RESET;
            rdata_r <= 32'h0000_0000;
            ack_r <= 1'b0;
        end else begin
            sysctl_r <= sysctl_nxt;
            routing_r <= routing_nxt;
            ident_r <= ident_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    // =================================================================
    // Serial EEPROM load
    // The load starts when the gated reset releases; a suspended reset never restarts it.
    ee_state_e ee_st_r, ee_st_nxt;
    logic [31:0] ee_sh_r, ee_sh_nxt;
    logic [5:0] ee_cnt_r, ee_cnt_nxt;
    logic ee_loaded_r, ee_loaded_nxt;

    always_comb begin
        ee_st_nxt = ee_st_r;
        ee_sh_nxt = ee_sh_r;
        ee_cnt_nxt = ee_cnt_r;
        ee_loaded_nxt = ee_loaded_r;
        ee_load = 1'b0;
        unique case (ee_st_r)
            EE_IDLE: begin
                ee_st_nxt = EE_SHIFT;
                ee_cnt_nxt = 6'h00;
            end
            EE_SHIFT: begin
                if (ee_bit_valid) begin
                    ee_sh_nxt = {ee_sh_r[30:0], ee_data_in};
                    ee_cnt_nxt = ee_cnt_r + 6'h01;
                    if (ee_cnt_r == 6'(EE_BITS - 1)) begin
                        ee_st_nxt = EE_DONE;
                    end
                end
            end
            EE_DONE: begin
                // One copy per reset, so a later firmware write under the enable bit sticks.
                ee_load = !ee_loaded_r;
                ee_loaded_nxt = 1'b1;
                ee_st_nxt = EE_DONE;
            end
        endcase
    end
    assign ee_word = ee_sh_r;

    always_ff @(posedge clock) begin
        if (core_rst) begin
            ee_st_r <= EE_IDLE;
            ee_sh_r <= 32'h0000_0000;
            ee_cnt_r <= 6'h00;
            ee_loaded_r <= 1'b0;
        end else begin
            ee_st_r <= ee_st_nxt;
            ee_sh_r <= ee_sh_nxt;
            ee_cnt_r <= ee_cnt_nxt;
            ee_loaded_r <= ee_loaded_nxt;
        end
    end

    // =================================================================
    // Lock tracking
    logic lock_req;
    lock_state_e lk_st_r, lk_st_nxt;
    logic [27:0] lk_blk_r, lk_blk_nxt;
    logic same_blk;

    always_comb begin
        // Lock arrives on terminal four only when routing selects it.
        if (routing_r[`TERM4_FIELD_LSB +: 4] == `TERM4_SEL_LOCK) begin
            lock_req = multipurpose_terminal_four_in;
        end else begin
            lock_req = lock_pin_in;
        end
    end

    assign same_blk = xact.addr[31:`LOCK_BLOCK_LSB] == lk_blk_r;

    always_comb begin
        lk_st_nxt = lk_st_r;
        lk_blk_nxt = lk_blk_r;
        unique case (lk_st_r)
            LK_IDLE: begin
                // A grant alone is not enough; only a locked downstream access starts ownership.
                if (lock_req && xact.valid && xact.locked && xact.downstream) begin
                    lk_st_nxt = LK_ACQUIRE;
                    lk_blk_nxt = xact.addr[31:`LOCK_BLOCK_LSB];
                end
            end
            LK_ACQUIRE: begin
                lk_st_nxt = lock_req ? LK_HELD : LK_IDLE;
            end
            LK_HELD: begin
                if (!lock_req) begin
                    lk_st_nxt = LK_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (core_rst) begin
            lk_st_r <= LK_IDLE;
            lk_blk_r <= 28'h000_0000;
        end else begin
            lk_st_r <= lk_st_nxt;
            lk_blk_r <= lk_blk_nxt;
        end
    end

    logic locked_now;
    assign locked_now = lk_st_r != LK_IDLE;

    // Interleaved traffic outside the block passes; inside it only the owner's locked access.
    always_comb begin
        xact_allow = !(locked_now && xact.valid && same_blk && !xact.locked);
    end

    // =================================================================
    // Outputs other than xact_allow, released while global reset is held
    // Posting stays off while locked, avoiding deadlock against delayed-read targets.
    assign posting_enable = !locked_now && !global_reset_input;
    assign card_side_lock_out = 1'b0;
    assign card_side_lock_oe = locked_now && !global_reset_input;
    assign cfg_rdata = global_reset_input ? 32'h0000_0000 : rdata_r;
    assign cfg_ack = ack_r && !global_reset_input;
    assign ee_busy = ee_st_r == EE_SHIFT && !global_reset_input;

    // =================================================================
    // Checks
    sequence s_lock_start;
        lk_st_r == LK_IDLE && lock_req && xact.valid && xact.locked && xact.downstream;
    endsequence

    AST_UPSTREAM_NO_LOCK: assert property (@(posedge clock) disable iff (core_rst)
        lk_st_r == LK_IDLE && !xact.downstream |=> lk_st_r == LK_IDLE)
        else $error("upstream access took the lock");
    AST_FOREIGN_BLOCKED: assert property (@(posedge clock) disable iff (core_rst)
        locked_now && xact.valid && !xact.locked && same_blk |-> !xact_allow)
        else $error("access to locked block allowed");
    AST_OUTSIDE_PASSES: assert property (@(posedge clock) disable iff (core_rst)
        locked_now && !same_blk |-> xact_allow)
        else $error("access outside locked block refused");
    AST_NO_POSTING: assert property (@(posedge clock) disable iff (core_rst)
        s_lock_start |=> !posting_enable)
        else $error("posting enabled during lock");
    AST_RELEASE: assert property (@(posedge clock)
        disable iff (core_rst || global_reset_input)
        lk_st_r == LK_HELD && !lock_req |=> posting_enable && !card_side_lock_oe)
        else $error("lock not released");
    AST_IDENT_RO: assert property (@(posedge clock) disable iff (core_rst)
        !sysctl_r[`BIT_IDENT_WRITE_ENABLE] && !ee_load |=> $stable(ident_r))
        else $error("identification written while read only");
    AST_EE_LOAD: assert property (@(posedge clock) disable iff (core_rst)
        ee_load |=> ident_r == $past(ee_sh_r))
        else $error("eeprom word not loaded");
    AST_GLOBAL_RESET_INPUT_HIZ: assert property (@(posedge clock)
        global_reset_input |-> !card_side_lock_oe && !posting_enable && !cfg_ack && !ee_busy)
        else $error("output driven during global reset");
endmodule
`default_nettype wire

// ==== sim/ee_model.sv ====
// Serial EEPROM stand-in that streams one identification word, MSB first.
`timescale 1ns/10ps
`default_nettype none
module ee_model (
    input wire logic clock,
    input wire logic start,
    input wire logic [31:0] word,
    output logic data,
    output logic valid
);
    int idx = -1;
    logic slow = 1'b0;
    initial begin
        data = 1'b0;
        valid = 1'b0;
    end
    // A bit is offered only every other cycle, so the loader must wait for valid.
    logic go;
    // Start is taken at the edge itself, so a pulse lowered just after it is still seen.
    always @(posedge clock) begin
        go = start;
        #1;
        slow = ~slow;
        if (go && idx < 0) begin
            idx = 31;
        end
        if (idx >= 0 && slow) begin
            data = word[idx];
            valid = 1'b1;
            idx = idx - 1;
        end else begin
            data = ~data;
            valid = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== sim/pci_lock_and_subsystem_id_tb.sv ====
// Self-checking bench for lock handling and identification loading.
`timescale 1ns/10ps
`include "lock_ident_map.svh"
`default_nettype none
module pci_lock_and_subsystem_id_tb;
    import lock_ident_pkg::*;
    logic clock = 1'b0, sys_rst = 1'b1, global_reset_input = 1'b0, suspend_in = 1'b0;
    logic lock_pin_in = 1'b0, multipurpose_terminal_four_in = 1'b0, card_side_lock_in = 1'b1;
    logic ee_start = 1'b0, ee_data_in, ee_bit_valid, cfg_ack, xact_allow, posting_enable;
    logic card_side_lock_out, card_side_lock_oe, ee_busy;
    logic [31:0] cfg_rdata, id_val, ee_word;
    cfg_req_s cfg_req = '0;
    xact_s xact = '0;
    logic [32:0] notes[$];
    logic [32:0] note;
    int num_errors = 0, n_tests = 0, seed = 32'h664e;
    always #5 clock = ~clock;
    pci_lock_and_subsystem_id dut (.clock(clock), .sys_rst(sys_rst),
        .global_reset_input(global_reset_input), .suspend_in(suspend_in), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .lock_pin_in(lock_pin_in),
        .multipurpose_terminal_four_in(multipurpose_terminal_four_in), .xact(xact),
        .xact_allow(xact_allow), .posting_enable(posting_enable),
        .card_side_lock_in(card_side_lock_in), .card_side_lock_out(card_side_lock_out),
        .card_side_lock_oe(card_side_lock_oe), .ee_data_in(ee_data_in),
        .ee_bit_valid(ee_bit_valid), .ee_busy(ee_busy));
    ee_model eem (.clock(clock), .start(ee_start), .word(ee_word), .data(ee_data_in),
        .valid(ee_bit_valid));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic w, input logic f, input logic [7:0] a,
                       input logic [31:0] d, input logic [31:0] exp);
        @(posedge clock);
        #1;
        cfg_req = '{1'b1, w, f, a, d};
        notes.push_back({~w, exp});
        @(posedge clock);
        #1;
        cfg_req = '0;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic ee_fetch();
        ee_start = 1'b1;
        step(1);
        ee_start = 1'b0;
        for (int i = 0; i < 200 && ee_busy !== 1'b0; i++) step(1);
    endtask
    task automatic report_and_stop();
        // An answer that never came leaves its note behind.
        if (notes.size() != 0) begin
            num_errors++;
        end
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Oldest note is matched against each acknowledge; writes carry no check.
    always @(posedge clock) begin
        if (cfg_ack === 1'b1) begin
            if (notes.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                note = notes.pop_front();
                if (note[32]) begin
                    chk(cfg_rdata, note[31:0]);
                end
            end
        end
    end
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        id_val = $random(seed);
        ee_word = $random(seed);
        step(16);
        sys_rst = 1'b0;
        cfg(1, 0, `OFS_SUBSYS_IDENT, ~id_val, 32'h0);
        cfg(0, 0, `OFS_SUBSYS_IDENT, 0, `IDENT_RESET);
        cfg(1, 0, `OFS_SYSTEM_CONTROL, 32'h0000_0020, 0);
        cfg(1, 1, `OFS_SUBSYS_IDENT, id_val, 0);
        cfg(0, 0, `OFS_SUBSYS_IDENT, 0, id_val);
        cfg(1, 0, `OFS_SYSTEM_CONTROL, 32'h0, 0);
        cfg(1, 0, `OFS_SUBSYS_IDENT, ~id_val, 0);
        cfg(0, 1, `OFS_SUBSYS_IDENT, 0, id_val);
        cfg(0, 0, `OFS_SYSTEM_CONTROL, 0, 32'h0);
        ee_fetch();
        chk(ee_busy, 1'b0);
        cfg(0, 0, `OFS_SUBSYS_IDENT, 0, ee_word);
        cfg(0, 1, `OFS_SUBSYS_IDENT, 0, ee_word);
        cfg(0, 0, 8'h44, 0, 32'h0);
        // Upstream lock attempt must not engage the lock.
        lock_pin_in = 1'b1;
        xact = '{1'b1, 1'b0, 1'b1, 1'b1, 32'h1000_0020};
        step(1);
        chk(posting_enable, 1'b1);
        xact.downstream = 1'b1;
        step(1);
        chk({posting_enable, card_side_lock_oe}, 2'b01);
        chk(card_side_lock_out, 1'b0);
        xact = '{1'b1, 1'b1, 1'b1, 1'b0, 32'h1000_002C};
        step(1);
        chk(xact_allow, 1'b0);
        xact.addr = 32'h1000_0030;
        step(1);
        chk(xact_allow, 1'b1);
        // Under the block lock a locked access inside the block and an unlocked access outside it both reach the bridge.
        xact = '{1'b1, 1'b1, 1'b1, 1'b1, 32'h1000_0024};
        step(1);
        chk(xact_allow, 1'b1);
        xact = '{1'b1, 1'b1, 1'b1, 1'b0, 32'h3000_0040};
        step(1);
        chk({xact_allow, posting_enable}, 2'b10);
        global_reset_input = 1'b1;
        step(1);
        chk({card_side_lock_oe, posting_enable, ee_busy}, 3'b000);
        global_reset_input = 1'b0;
        step(1);
        chk(card_side_lock_oe, 1'b1);
        lock_pin_in = 1'b0;
        xact = '0;
        for (int i = 0; i < 3 && card_side_lock_oe !== 1'b0; i++) step(1);
        chk({posting_enable, card_side_lock_oe}, 2'b10);
        cfg(1, 0, `OFS_MFUNC_ROUTING, 32'h0007_0000, 0);
        multipurpose_terminal_four_in = 1'b1;
        xact = '{1'b1, 1'b1, 1'b0, 1'b1, 32'h2000_0000};
        step(2);
        chk(posting_enable, 1'b0);
        multipurpose_terminal_four_in = 1'b0;
        xact = '0;
        suspend_in = 1'b1;
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        suspend_in = 1'b0;
        cfg(0, 0, `OFS_MFUNC_ROUTING, 0, 32'h0007_0000);
        // A plain bus reset clears the core and fetches the identification again.
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        ee_word = $random(seed);
        cfg(0, 0, `OFS_MFUNC_ROUTING, 0, `ROUTING_RESET);
        ee_fetch();
        cfg(0, 0, `OFS_SUBSYS_IDENT, 0, ee_word);
        cfg(1, 0, `OFS_SYSTEM_CONTROL, 32'h0000_0020, 0);
        cfg(1, 0, `OFS_SUBSYS_IDENT, id_val, 0);
        cfg(0, 0, `OFS_SUBSYS_IDENT, 0, id_val);
        step(4);
        report_and_stop();
    end
endmodule
`default_nettype wire
